// ===== core/tsb_pkg.sv
// Package with register map, field layout, timing and carrier types for the token serial bus controller
// Contract
// [RULE1] Counter steps 0..37 on serial rising edge
// [RULE2] Reset puts counter in state 0
// [RULE3] Message is four host-accessible bytes, 32 bits
// [RULE4] Top three message bits are destination address
// [RULE5] Top-byte read clears pending; bottom write clears request
// [RULE6] Only four control bits writable; TXREQ, PREV and CLKEN are set-only, IFLAG is write-one-clear
// [RULE7] Reset clears whole control/status register
// [RULE8] Master bit set if requesting at mastery change
// [RULE9] Data high in state 36 sets not-acknowledged
// [RULE10] Address match sets receive pending until read
// [RULE11] Unread previous message makes node deaf
// [RULE12] Clock-enable bit makes node drive serial clock
// [RULE13] Interrupt flag set by events, write-one clears
// [RULE14] Interrupt request from enable and three status bits
// [RULE15] State 0 request stops clock, pulls data low
// [RULE16] Entering state 1 updates previous-master bit
// [RULE17] Chain-out rules decide the next master
// [RULE18] New master releases data high in state 1
// [RULE19] State 2 stops clock, master raises flag
// [RULE20] Host loads message, bottom byte written last
// [RULE21] Loaded master pulls data low, clock resumes
// [RULE22] Software picks exactly one initial previous master
// [RULE23] States 3..34 shift message out and in
// [RULE24] Launch on rising edge, capture on falling edge
// [RULE25] Addressed listening node acknowledges in state 36
// [RULE26] Data line is wired-AND open drain
package tsb_pkg;

  // Register byte addresses
  localparam logic [7:0] TSB_OFS_MSG0     = 8'h00;
  localparam logic [7:0] TSB_OFS_MSG1     = 8'h04;
  localparam logic [7:0] TSB_OFS_MSG2     = 8'h08;
  localparam logic [7:0] TSB_OFS_MSG3     = 8'h0C;
  localparam logic [7:0] TSB_OFS_CSR      = 8'h10;
  localparam logic [7:0] TSB_OFS_STATE    = 8'h14;
  localparam logic [7:0] TSB_OFS_NODEADDR = 8'h18;
  localparam logic [7:0] TSB_OFS_BUSEN    = 8'h1C;

  // Control/status bit positions
  localparam int TSB_CSR_TXREQ  = 0;
  localparam int TSB_CSR_MASTER = 1;
  localparam int TSB_CSR_PREV   = 2;
  localparam int TSB_CSR_NACK   = 3;
  localparam int TSB_CSR_RPEND  = 4;
  localparam int TSB_CSR_DEAF   = 5;
  localparam int TSB_CSR_CLKEN  = 6;
  localparam int TSB_CSR_IFLAG  = 7;
  localparam logic [7:0] TSB_CSR_RESET   = 8'h00;
  localparam logic [7:0] TSB_CSR_SETMASK = 8'h45;

  // Message layout and bus counter
  localparam int TSB_ADDR_MSB = 31;
  localparam int TSB_ADDR_LSB = 29;
  localparam logic [5:0] TSB_ST_LAST    = 6'h25;
  localparam logic [5:0] TSB_ST_MSG_LO  = 6'h03;
  localparam logic [5:0] TSB_ST_MSG_HI  = 6'h22;
  localparam logic [5:0] TSB_ST_PREACK  = 6'h23;
  localparam logic [5:0] TSB_ST_ACK     = 6'h24;

  // Serial clock generation
  localparam int TSB_CLK_PERIOD_NS = 100;
  localparam int TSB_SCLK_HALF_NS  = 500;
  localparam logic [3:0] TSB_SCLK_HALF_CYC = 4'((TSB_SCLK_HALF_NS + TSB_CLK_PERIOD_NS - 1) / TSB_CLK_PERIOD_NS);

  // AXI4-Lite responses
  localparam logic [1:0] TSB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TSB_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tsb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tsb_axi_rsp_t;

  typedef struct packed {
    logic sclk_i;
    logic shared_data_line_i;
    logic chain_in;
  } tsb_pin_in_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic shared_data_line_o;
    logic shared_data_line_oe;
    logic chain_out;
  } tsb_pin_out_t;

endpackage

// ===== core/tsb_controller.sv
// Token serial bus controller with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tsb_controller (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register bus
  input  wire tsb_pkg::tsb_axi_req_t axi_req,
  output tsb_pkg::tsb_axi_rsp_t      axi_rsp,
  // Bus pins
  input  wire tsb_pkg::tsb_pin_in_t  pin_in,
  output tsb_pkg::tsb_pin_out_t      pin_out,
  // Interrupt
  output logic                       bus_interrupt_request
);
  import tsb_pkg::*;

  typedef struct packed {
    tsb_axi_rsp_t rsp;
    logic         aw_got;
    logic [7:0]   aw_addr;
    logic         w_got;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic [31:0]  msg;
    logic [7:0]   csr;
    logic [2:0]   node_addr;
    logic         bus_enable_control;
    logic         token;
    logic [5:0]   cnt;
    logic         sclk_q;
    logic         tx_bit;
    logic [3:0]   div;
    tsb_pin_out_t pins;
    logic         irq;
  } tsb_state_t;

  tsb_state_t st_r;
  tsb_state_t st_nxt;

  // Next counter value, wrapping after the last state
  function automatic logic [5:0] tsb_next_cnt(input logic [5:0] c);
    tsb_next_cnt = (c == TSB_ST_LAST) ? 6'h00 : c + 6'h01;
  endfunction

  // Counter value to the one-hot code software sees
  function automatic logic [7:0] tsb_state_code(input logic [5:0] c);
    if (c == 6'h00) begin
      tsb_state_code = 8'h01;
    end else if (c == 6'h01) begin
      tsb_state_code = 8'h02;
    end else if (c == 6'h02) begin
      tsb_state_code = 8'h04;
    end else if (c <= TSB_ST_MSG_HI) begin
      tsb_state_code = 8'h08;
    end else if (c == TSB_ST_PREACK) begin
      tsb_state_code = 8'h10;
    end else if (c == TSB_ST_ACK) begin
      tsb_state_code = 8'h20;
    end else begin
      tsb_state_code = 8'h40;
    end
  endfunction

  // Register read mux; unmapped gives an error flag
  function automatic logic [32:0] tsb_read(input tsb_state_t s, input logic [7:0] a);
    case ({a[7:2], 2'b00})
      TSB_OFS_MSG0:     tsb_read = {1'b0, 24'h000000, s.msg[7:0]};
      TSB_OFS_MSG1:     tsb_read = {1'b0, 24'h000000, s.msg[15:8]};
      TSB_OFS_MSG2:     tsb_read = {1'b0, 24'h000000, s.msg[23:16]};
      TSB_OFS_MSG3:     tsb_read = {1'b0, 24'h000000, s.msg[31:24]};
      TSB_OFS_CSR:      tsb_read = {1'b0, 24'h000000, s.csr};
      TSB_OFS_STATE:    tsb_read = {1'b0, 24'h000000, tsb_state_code(s.cnt)};
      TSB_OFS_NODEADDR: tsb_read = {1'b0, 29'h00000000, s.node_addr};
      TSB_OFS_BUSEN:    tsb_read = {1'b0, 31'h00000000, s.bus_enable_control};
      default:          tsb_read = {1'b1, 32'h00000000};
    endcase
  endfunction

  logic        sclk_rise;
  logic        sclk_fall;
  logic        addr_match;
  logic        do_write;
  logic        do_read;
  logic [32:0] rd;
  logic [7:0]  wb;

  // Edge detection on the shared serial clock and access strobes
  assign sclk_rise  = pin_in.sclk_i & ~st_r.sclk_q;
  assign sclk_fall  = ~pin_in.sclk_i & st_r.sclk_q;
  assign addr_match = (st_r.msg[TSB_ADDR_MSB:TSB_ADDR_LSB] == st_r.node_addr); // [RULE4]
  assign do_write   = st_r.aw_got & st_r.w_got & ~st_r.rsp.bvalid;
  assign do_read    = axi_req.arvalid & st_r.rsp.arready;
  assign rd         = tsb_read(st_r, axi_req.araddr);
  assign wb         = st_r.w_data[7:0];

  // Whole next-state computation
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_q = pin_in.sclk_i;

    // Write channels are taken in either order, then one response
    if (axi_req.awvalid & st_r.rsp.awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid & st_r.rsp.wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = axi_req.wdata;
      st_nxt.w_strb = axi_req.wstrb;
    end
    if (st_r.rsp.bvalid & axi_req.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    if (do_write) begin
      st_nxt.aw_got       = 1'b0;
      st_nxt.w_got        = 1'b0;
      st_nxt.rsp.bvalid   = 1'b1;
      st_nxt.rsp.bresp    = TSB_RESP_OKAY;
      // Only lane 0 carries register data; other lanes are dropped
      if (st_r.w_strb[0]) begin
        case ({st_r.aw_addr[7:2], 2'b00})
          TSB_OFS_MSG0: begin
            st_nxt.msg[7:0] = wb; // [RULE3]
            st_nxt.csr[TSB_CSR_TXREQ] = 1'b0; // [RULE5] [RULE20]
          end
          TSB_OFS_MSG1:     st_nxt.msg[15:8]  = wb; // [RULE3]
          TSB_OFS_MSG2:     st_nxt.msg[23:16] = wb; // [RULE3]
          TSB_OFS_MSG3:     st_nxt.msg[31:24] = wb; // [RULE3]
          TSB_OFS_CSR: begin
            st_nxt.csr = st_nxt.csr | (wb & TSB_CSR_SETMASK); // [RULE6] [RULE12]
            if (wb[TSB_CSR_PREV]) begin
              st_nxt.token = 1'b1; // [RULE22]
            end
            if (wb[TSB_CSR_IFLAG]) begin
              st_nxt.csr[TSB_CSR_IFLAG] = 1'b0; // [RULE13]
            end
          end
          TSB_OFS_NODEADDR: st_nxt.node_addr = wb[2:0];
          TSB_OFS_BUSEN:    st_nxt.bus_enable_control = wb[0];
          TSB_OFS_STATE:    st_nxt.rsp.bresp = TSB_RESP_OKAY;
          default:          st_nxt.rsp.bresp = TSB_RESP_SLVERR;
        endcase
      end else if (tsb_read(st_r, st_r.aw_addr) >> 32 != 33'h0) begin
        st_nxt.rsp.bresp = TSB_RESP_SLVERR;
      end
    end

    // Read channel; a read of the top byte releases the pending message
    if (st_r.rsp.rvalid & axi_req.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    if (do_read) begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata  = rd[31:0];
      st_nxt.rsp.rresp  = rd[32] ? TSB_RESP_SLVERR : TSB_RESP_OKAY;
      if ({axi_req.araddr[7:2], 2'b00} == TSB_OFS_MSG3) begin
        st_nxt.csr[TSB_CSR_RPEND] = 1'b0; // [RULE5] [RULE10]
      end
    end

    // Falling edge captures the bit on the line while listening
    if (sclk_fall && st_r.cnt >= TSB_ST_MSG_LO && st_r.cnt <= TSB_ST_MSG_HI
        && !st_r.csr[TSB_CSR_DEAF]) begin
      st_nxt.msg = {st_r.msg[30:0], pin_in.shared_data_line_i}; // [RULE23] [RULE24]
    end

    // Rising edge advances the bus timing counter and its events
    if (sclk_rise) begin
      st_nxt.cnt = tsb_next_cnt(st_r.cnt); // [RULE1]
      case (st_r.cnt)
        6'h00: begin
          st_nxt.csr[TSB_CSR_PREV] = st_r.token; // [RULE16]
        end
        6'h01: begin
          // Winner is the first requester downstream of the old master
          st_nxt.token = st_r.csr[TSB_CSR_TXREQ] & pin_in.chain_in;
          st_nxt.csr[TSB_CSR_MASTER] = st_r.csr[TSB_CSR_TXREQ] & pin_in.chain_in; // [RULE8]
          if (st_r.csr[TSB_CSR_TXREQ] & pin_in.chain_in) begin
            st_nxt.csr[TSB_CSR_IFLAG] = 1'b1; // [RULE19]
          end
        end
        6'h02: begin
          st_nxt.csr[TSB_CSR_DEAF] = st_r.csr[TSB_CSR_RPEND]; // [RULE11]
        end
        TSB_ST_ACK: begin
          if (st_r.csr[TSB_CSR_MASTER]) begin
            st_nxt.csr[TSB_CSR_NACK] = pin_in.shared_data_line_i; // [RULE9]
            if (pin_in.shared_data_line_i) begin
              st_nxt.csr[TSB_CSR_IFLAG] = 1'b1; // [RULE13]
            end
          end else if (addr_match && !st_r.csr[TSB_CSR_DEAF]) begin
            st_nxt.csr[TSB_CSR_RPEND] = 1'b1; // [RULE10]
            st_nxt.csr[TSB_CSR_IFLAG] = 1'b1; // [RULE13]
          end
        end
        default: begin
          st_nxt.cnt = tsb_next_cnt(st_r.cnt);
        end
      endcase
      st_nxt.tx_bit = st_r.msg[31]; // [RULE24]
    end

    // Serial clock generator, held low while the bus waits on a request
    if (!st_r.csr[TSB_CSR_CLKEN]) begin
      st_nxt.pins.sclk_o = 1'b0;
      st_nxt.div         = 4'h0;
    end else if (!st_r.pins.sclk_o && (st_r.cnt == 6'h00 || st_r.cnt == 6'h02) && pin_in.shared_data_line_i) begin
      st_nxt.div = 4'h0; // [RULE15] [RULE19]
    end else if (st_r.div == TSB_SCLK_HALF_CYC - 4'h1) begin
      st_nxt.div         = 4'h0;
      st_nxt.pins.sclk_o = ~st_r.pins.sclk_o; // [RULE12] [RULE21]
    end else begin
      st_nxt.div = st_r.div + 4'h1;
    end
    st_nxt.pins.sclk_oe = st_r.csr[TSB_CSR_CLKEN]; // [RULE12]

    // Chain-out carries the token only in the arbitration state
    st_nxt.pins.chain_out = (st_nxt.cnt == 6'h01) &&
                            (st_nxt.csr[TSB_CSR_PREV] ||
                             (pin_in.chain_in && !st_nxt.csr[TSB_CSR_TXREQ])); // [RULE17]

    // Open-drain data line: only ever pulled low, released means high
    st_nxt.pins.shared_data_line_o  = 1'b0; // [RULE26]
    st_nxt.pins.shared_data_line_oe = 1'b0; // [RULE18]
    if (st_nxt.cnt == 6'h00 && st_nxt.csr[TSB_CSR_TXREQ]) begin
      st_nxt.pins.shared_data_line_oe = 1'b1; // [RULE15]
    end else if (st_nxt.cnt == 6'h02 && st_nxt.csr[TSB_CSR_MASTER] && !st_nxt.csr[TSB_CSR_TXREQ]) begin
      st_nxt.pins.shared_data_line_oe = 1'b1; // [RULE21]
    end else if (st_nxt.cnt >= TSB_ST_MSG_LO && st_nxt.cnt <= TSB_ST_MSG_HI && st_nxt.csr[TSB_CSR_MASTER]) begin
      st_nxt.pins.shared_data_line_oe = ~st_nxt.tx_bit; // [RULE23]
    end else if (st_nxt.cnt == TSB_ST_ACK && !st_nxt.csr[TSB_CSR_MASTER] && !st_nxt.csr[TSB_CSR_DEAF]
                 && st_nxt.msg[TSB_ADDR_MSB:TSB_ADDR_LSB] == st_nxt.node_addr) begin
      st_nxt.pins.shared_data_line_oe = 1'b1; // [RULE25]
    end

    // Ready flags are registered so every output comes from a flop
    st_nxt.rsp.awready = ~st_nxt.aw_got & ~st_nxt.rsp.bvalid;
    st_nxt.rsp.wready  = ~st_nxt.w_got & ~st_nxt.rsp.bvalid;
    st_nxt.rsp.arready = ~st_nxt.rsp.rvalid;
    st_nxt.irq = st_nxt.bus_enable_control &
                 (st_nxt.csr[TSB_CSR_MASTER] | st_nxt.csr[TSB_CSR_NACK] | st_nxt.csr[TSB_CSR_RPEND]); // [RULE14]
  end

  // Single state register; reset zeroes counter and control/status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r     <= '0; // [RULE2] [RULE7]
      st_r.csr <= TSB_CSR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axi_rsp               = st_r.rsp;
  assign pin_out               = st_r.pins;
  assign bus_interrupt_request = st_r.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Counter checks
  AST_CNT_WRAP: assert property (sclk_rise && st_r.cnt == 6'h25 |=> st_r.cnt == 6'h00) // [RULE1]
    else $error("counter did not wrap to 0");
  AST_CNT_STEP: assert property (sclk_rise && st_r.cnt != 6'h25 |=> st_r.cnt == $past(st_r.cnt) + 6'h01) // [RULE1]
    else $error("counter did not step by one");
  AST_RESET_CLR: assert property ($past(rst) |-> st_r.cnt == 6'h00 && st_r.csr == 8'h00) // [RULE2]
    else $error("reset left counter or status set");
  // Host access side effects
  AST_TXREQ_CLR: assert property (do_write && st_r.w_strb[0] && st_r.aw_addr[7:2] == 6'h00
                                  |=> !st_r.csr[TSB_CSR_TXREQ]) // [RULE5]
    else $error("bottom byte write left request set");
  AST_RPEND_CLR: assert property (do_read && axi_req.araddr[7:2] == 6'h03 && !(sclk_rise && st_r.cnt == 6'h24)
                                  |=> !st_r.csr[TSB_CSR_RPEND]) // [RULE5]
    else $error("top byte read left pending set");
  // Bus protocol events
  AST_NACK_SET: assert property (sclk_rise && st_r.cnt == 6'h24 && st_r.csr[TSB_CSR_MASTER] && pin_in.shared_data_line_i
                                 |=> st_r.csr[TSB_CSR_NACK] && st_r.csr[TSB_CSR_IFLAG]) // [RULE9]
    else $error("missing acknowledge not flagged");
  AST_DEAF_SET: assert property (sclk_rise && st_r.cnt == 6'h02 && st_r.csr[TSB_CSR_RPEND]
                                 |=> st_r.csr[TSB_CSR_DEAF] ##1 st_r.csr[TSB_CSR_DEAF]) // [RULE11]
    else $error("unread node not made deaf");
  AST_CHAIN_PREV: assert property (st_r.cnt == 6'h01 && st_r.csr[TSB_CSR_PREV] |-> pin_out.chain_out) // [RULE17]
    else $error("previous master did not pass the token");
  // Request must follow the enable and the three status bits as they stand now
  AST_IRQ_OUT: assert property (bus_interrupt_request == (st_r.bus_enable_control && (st_r.csr[TSB_CSR_MASTER]
                                || st_r.csr[TSB_CSR_NACK] || st_r.csr[TSB_CSR_RPEND]))) // [RULE14]
    else $error("interrupt request mismatch");
  AST_SCLK_STOP: assert property (st_r.csr[TSB_CSR_CLKEN] && !pin_out.sclk_o && st_r.cnt == 6'h00
                                  && pin_in.shared_data_line_i [*2] |=> !pin_out.sclk_o) // [RULE15]
    else $error("serial clock ran in idle state 0");
  // A bottom byte write may withdraw the request, so it must still stand in the second cycle
  AST_REQ_PULL: assert property (st_r.cnt == 6'h00 && st_r.csr[TSB_CSR_TXREQ]
                                 ##1 st_r.cnt == 6'h00 && st_r.csr[TSB_CSR_TXREQ]
                                 |-> pin_out.shared_data_line_oe) // [RULE15]
    else $error("request did not pull data low");

endmodule

// ===== tb/tsb_peer_node.sv
// Peer node model on the ring: counts bus states, listens and acknowledges
`timescale 1ns/1ps
module tsb_peer_node #(
  parameter logic [2:0] PEER_ADDR = 3'h3
) (
  // Bus pins
  input  logic        sclk,
  input  logic        shared_data_line,
  input  logic        chain_in,
  output logic        chain_out,
  output logic        shared_data_line_pull_low,
  // Control and observation
  input  logic        rst,
  input  logic        ack_en,
  input  logic        tx_go,
  input  logic [31:0] tx_word,
  output logic        ack_seen,
  output logic [31:0] rx_word
);
  logic [5:0]  st_r;
  logic        mst_r;
  logic [31:0] sh_r;
  logic        ack_r;

  // Bus timing counter; a requesting peer wins the token at the 1 to 2 edge and launches on rising edges
  always @(posedge sclk or posedge rst) begin
    if (rst) begin
      st_r     <= 6'h00;
      mst_r    <= 1'b0;
      sh_r     <= 32'h0000_0000;
      ack_seen <= 1'b0;
    end else begin
      st_r <= (st_r == 6'h25) ? 6'h00 : st_r + 6'h01;
      if (st_r == 6'h01) begin
        mst_r <= tx_go & chain_in;
        sh_r  <= tx_word;
      end else if (st_r >= 6'h03 && st_r <= 6'h22) begin
        sh_r <= {sh_r[30:0], 1'b0};
      end
      if (st_r == 6'h24) begin
        ack_seen <= ~shared_data_line;
      end
    end
  end

  // Ack is driven from a falling edge so it spans the whole 36 to 37 rising edge
  always @(negedge sclk or posedge rst) begin
    if (rst) begin
      rx_word <= 32'h0000_0000;
      ack_r   <= 1'b0;
    end else begin
      if (st_r >= 6'h03 && st_r <= 6'h22) begin
        rx_word <= {rx_word[30:0], shared_data_line};
      end
      ack_r <= ack_en && st_r == 6'h24 && rx_word[31:29] == PEER_ADDR;
    end
  end

  // Pulls: bus request, clock request as master, message zeros and acknowledge
  assign shared_data_line_pull_low = ack_r | (tx_go && st_r == 6'h00) | (mst_r && st_r == 6'h02)
                         | (mst_r && st_r >= 6'h03 && st_r <= 6'h22 && !sh_r[31]);

  // Last master passes the token on; a requesting peer keeps it
  assign chain_out = mst_r | (chain_in & ~tx_go);
endmodule

// ===== tb/token_ring_serial_bus_controller_tb.sv
// Self-checking bench: register access, mastery and message transfer to a peer node
`timescale 1ns/1ps
module token_ring_serial_bus_controller_tb;
  import tsb_pkg::*;

  typedef struct packed {
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [1:0]  wresp;
    logic [31:0] rexp;
    logic [1:0]  rresp;
  } tsb_row_t;

  logic         clk_sys;
  logic         rst;
  tsb_axi_req_t axi_req;
  tsb_axi_rsp_t axi_rsp;
  tsb_pin_in_t  pin_in;
  tsb_pin_out_t pin_out;
  logic         bus_interrupt_request;
  logic         peer_low;
  logic         peer_chain;
  logic         ack_en;
  logic         tx_go;
  logic [31:0]  tx_word;
  logic         ack_seen;
  logic         sclk_wire;
  logic         shared_data_line_wire;
  logic [31:0]  peer_word;
  logic [31:0]  rd;
  logic [1:0]   resp;
  int           bad_count;
  int           comparisons;

  // Write then read back each row; upper data bits must read zero
  tsb_row_t rows [8] = '{
    '{TSB_OFS_MSG1, 32'h0000_01A5, TSB_RESP_OKAY, 32'h0000_00A5, TSB_RESP_OKAY},
    '{TSB_OFS_MSG2, 32'h0000_003C, TSB_RESP_OKAY, 32'h0000_003C, TSB_RESP_OKAY},
    '{TSB_OFS_MSG3, 32'h0000_007C, TSB_RESP_OKAY, 32'h0000_007C, TSB_RESP_OKAY},
    '{TSB_OFS_NODEADDR, 32'h0000_00FD, TSB_RESP_OKAY, 32'h0000_0005, TSB_RESP_OKAY},
    '{TSB_OFS_STATE, 32'h0000_00FF, TSB_RESP_OKAY, 32'h0000_0001, TSB_RESP_OKAY},
    '{8'h20, 32'h0000_00FF, TSB_RESP_SLVERR, 32'h0000_0000, TSB_RESP_SLVERR},
    '{TSB_OFS_CSR, 32'h0000_00BA, TSB_RESP_OKAY, 32'h0000_0000, TSB_RESP_OKAY},
    '{TSB_OFS_BUSEN, 32'h0000_0001, TSB_RESP_OKAY, 32'h0000_0001, TSB_RESP_OKAY}
  };

  // Clock line pulled low when undriven; data line is wired-AND with a pull-up
  assign sclk_wire = pin_out.sclk_oe & pin_out.sclk_o;
  assign shared_data_line_wire = ~((pin_out.shared_data_line_oe & ~pin_out.shared_data_line_o) | peer_low);
  assign pin_in    = {sclk_wire, shared_data_line_wire, peer_chain};

  tsb_controller u_dut (
    .clk_sys               (clk_sys),
    .rst                   (rst),
    .axi_req               (axi_req),
    .axi_rsp               (axi_rsp),
    .pin_in                (pin_in),
    .pin_out               (pin_out),
    .bus_interrupt_request (bus_interrupt_request)
  );

  tsb_peer_node u_peer (
    .sclk          (sclk_wire),
    .shared_data_line          (shared_data_line_wire),
    .chain_in      (pin_out.chain_out),
    .chain_out     (peer_chain),
    .shared_data_line_pull_low (peer_low),
    .rst           (rst),
    .ack_en        (ack_en),
    .tx_go         (tx_go),
    .tx_word       (tx_word),
    .ack_seen      (ack_seen),
    .rx_word       (peer_word)
  );

  // 10 MHz system clock
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      comparisons++;
      if (got !== exp) begin
        bad_count++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // Write with both channels offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    begin
      n = 0;
      axi_req.awvalid <= 1'b1;
      axi_req.awaddr  <= a;
      axi_req.wvalid  <= 1'b1;
      axi_req.wdata   <= d;
      axi_req.wstrb   <= 4'hF;
      axi_req.bready  <= 1'b1;
      do begin
        @(posedge clk_sys);
        n++;
        if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
        if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (!(axi_rsp.bvalid && axi_req.bready) && n < 200);
      r = axi_rsp.bresp;
      axi_req.bready <= 1'b0;
      check("write handshake", 32'h1, {31'h0, n < 200});
      @(posedge clk_sys);
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    begin
      n = 0;
      axi_req.arvalid <= 1'b1;
      axi_req.araddr  <= a;
      axi_req.rready  <= 1'b1;
      do begin
        @(posedge clk_sys);
        n++;
        if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (!(axi_rsp.rvalid && axi_req.rready) && n < 200);
      check("read handshake", 32'h1, {31'h0, n < 200});
      d = axi_rsp.rdata;
      r = axi_rsp.rresp;
      axi_req.rready <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  // Poll the state register; bounded so a stuck counter shows up as a mismatch
  task automatic wait_state(input logic [31:0] want);
    int n;
    begin
      n = 0;
      do begin
        axi_rd(TSB_OFS_STATE, rd, resp);
        n++;
      end while (rd !== want && n < 400);
      check("bus state", want, rd);
    end
  endtask

  // One full mastered message; peer acknowledges only when asked
  task automatic send_msg(input logic ack);
    begin
      ack_en <= ack;
      axi_wr(TSB_OFS_CSR, 32'h81, resp);
      wait_state(32'h04);
      axi_rd(TSB_OFS_CSR, rd, resp);
      check("mastery status", 32'h07, rd & 32'h07);
      check("mastery flag", 32'h80, rd & 32'h80);
      check("request on mastery", 32'h1, {31'h0, bus_interrupt_request});
      // Host services the mastery flag so only the transfer result can raise it again
      axi_wr(TSB_OFS_CSR, 32'h80, resp);
      axi_wr(TSB_OFS_MSG0, 32'h5A, resp);
      axi_rd(TSB_OFS_CSR, rd, resp);
      check("request cleared", 32'h0, rd & 32'h01);
      wait_state(32'h20);
      wait_state(32'h01);
      check("peer word", 32'h7C3C_A55A, peer_word);
      axi_rd(TSB_OFS_MSG0, rd, resp);
      check("master own word", 32'h5A, rd);
      axi_rd(TSB_OFS_CSR, rd, resp);
      check("not acknowledged", {28'h0, !ack, 3'h0}, rd & 32'h08);
      check("result flag", {24'h0, !ack, 7'h0}, rd & 32'h80);
    end
  endtask

  task automatic test_done;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask

  // Watchdog: the whole run needs a few thousand cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    $display("watchdog expired");
    test_done();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    axi_req = '0;
    ack_en = 1'b0;
    tx_go = 1'b0;
    tx_word = 32'h0000_0000;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check("request after reset", 32'h0, {31'h0, bus_interrupt_request});
    axi_rd(TSB_OFS_CSR, rd, resp);
    check("status after reset", 32'h0, rd);
    axi_rd(TSB_OFS_STATE, rd, resp);
    check("state after reset", 32'h1, rd);
    $display("test reset done");
    foreach (rows[i]) begin
      axi_wr(rows[i].waddr, rows[i].wdata, resp);
      check("write response", {30'h0, rows[i].wresp}, {30'h0, resp});
      axi_rd(rows[i].waddr, rd, resp);
      check("read data", rows[i].rexp, rd);
      check("read response", {30'h0, rows[i].rresp}, {30'h0, resp});
    end
    $display("test register table done");
    // This node alone is chosen as previous master and clock source
    axi_wr(TSB_OFS_CSR, 32'h44, resp);
    axi_rd(TSB_OFS_CSR, rd, resp);
    check("control bits set", 32'h44, rd);
    check("clock drive", 32'h1, {31'h0, pin_out.sclk_oe});
    send_msg(1'b1);
    $display("test acknowledged message done");
    send_msg(1'b0);
    check("flag on missing ack", 32'h80, rd & 32'h80);
    check("request on missing ack", 32'h1, {31'h0, bus_interrupt_request});
    axi_wr(TSB_OFS_CSR, 32'h00, resp);
    axi_rd(TSB_OFS_CSR, rd, resp);
    check("write of zero", 32'h88, rd & 32'h88);
    axi_wr(TSB_OFS_CSR, 32'h80, resp);
    axi_rd(TSB_OFS_CSR, rd, resp);
    check("flag cleared", 32'h08, rd & 32'h88);
    axi_wr(TSB_OFS_BUSEN, 32'h0, resp);
    repeat (2) @(posedge clk_sys);
    check("request masked", 32'h0, {31'h0, bus_interrupt_request});
    $display("test missing acknowledge done");
    // Peer sends to this node twice; the second arrives while the first is unread
    tx_word <= 32'hB1C2_D3E4;
    tx_go   <= 1'b1;
    wait_state(32'h08);
    tx_go <= 1'b0;
    wait_state(32'h01);
    check("ack to peer", 32'h1, {31'h0, ack_seen});
    axi_rd(TSB_OFS_CSR, rd, resp);
    check("receive status", 32'h90, rd & 32'hB0);
    axi_rd(TSB_OFS_MSG2, rd, resp);
    check("received byte", 32'hC2, rd);
    tx_word <= 32'hA0F0_0F0F;
    tx_go   <= 1'b1;
    wait_state(32'h08);
    tx_go <= 1'b0;
    wait_state(32'h01);
    check("ack while deaf", 32'h0, {31'h0, ack_seen});
    axi_rd(TSB_OFS_CSR, rd, resp);
    check("deaf status", 32'h30, rd & 32'h30);
    axi_rd(TSB_OFS_MSG3, rd, resp);
    check("unread top byte", 32'hB1, rd);
    axi_rd(TSB_OFS_CSR, rd, resp);
    check("pending after read", 32'h0, rd & 32'h10);
    $display("test peer messages done");
    test_done();
  end
endmodule
